/* design/otp_config_pkg.sv */
// Constants, register map and command codes of the configuration bit store
// How it works
// - The store holds 56 configuration bits, each a shadow latch paired with a fuse.
// - A temporary write changes only the addressed shadow latch, a permanent write burns the fuse.
// - A burned fuse stays one forever and no command can clear it.
// - Power-on reset and the remote reset command clear every shadow latch.
// - An unburned fuse reads as zero.
// - With the source selector set and the part unlocked the active bits come from the latches, else from the fuses.
// - Each bit is written by one command byte that the store decodes.
// - Once the lock fuse is burned only precharge and remote reset are accepted, latches unusable.
// - Bit 0 is the lock bit; zero allows test and precharge, one is normal and blocks burning.
// - Bit 1 selects the measurement clock range, 4.000MHz band at zero, 8.000MHz band at one.
// - Bit 2 selects the oscillator, crystal at zero, RC at one.
// - Application mode 0 routes watchdog, zero crossing and energy pulses to the pins.
// - Application mode 1 routes the voltage and current bitstreams and the channel flag.
// - Application mode 2 drives the stepper, energy pulses, no-load, tamper and sign pins.
// - Application mode 3 is mode 2 with the LED rate taken from the pulse-constant field.
// - Each parity bit of a record is the odd parity of the seven matching data bits.
package otp_config_pkg;
   localparam int CFG_BITS = 56;
   localparam int REC_DATA = 28;
   localparam int REC_PAR  = 4;
   localparam int BIT_LOCK      = 0;
   localparam int BIT_CLK_RANGE = 1;
   localparam int BIT_OSC_TYPE  = 2;
   localparam int BIT_APP       = 3;
   localparam int BIT_PULSE_K   = 14;
   localparam logic [7:0] REG_CMD       = 8'h00;
   localparam logic [7:0] REG_MODE      = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_RECORD_LO = 8'h0c;
   localparam logic [7:0] REG_RECORD_HI = 8'h10;
   localparam logic [7:0] REG_SHADOW_LO = 8'h14;
   localparam logic [7:0] REG_SHADOW_HI = 8'h18;
   localparam logic [7:0] REG_FUSE_LO   = 8'h1c;
   localparam logic [7:0] REG_FUSE_HI   = 8'h20;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] OP_SHADOW_CLR = 2'h0;
   localparam logic [1:0] OP_SHADOW_SET = 2'h1;
   localparam logic [1:0] OP_BURN       = 2'h2;
   localparam logic [1:0] OP_SPECIAL    = 2'h3;
   localparam logic [5:0] SPC_PRECHARGE = 6'h00;
   localparam logic [5:0] SPC_REMOTE_RST = 6'h01;
   localparam logic [1:0] APP_PERIPH_WDOG  = 2'h0;
   localparam logic [1:0] APP_PERIPH_SD    = 2'h1;
   localparam logic [1:0] APP_STANDALONE   = 2'h2;
   localparam logic [1:0] APP_STANDALONE_K = 2'h3;
   localparam logic [CFG_BITS-1:0] SHADOW_RESET = '0;
   localparam logic [CFG_BITS-1:0] FUSE_BLANK   = '0;
endpackage

/* design/otp_config_bit_store.sv */
// Configuration bit store: shadow latches, fuses, source selection and pin routing
`timescale 1ns/1ps
module otp_config_bit_store (
   input  wire logic                                clk_sys,
   input  wire logic                                reset_n,
   input  wire logic [7:0]                          s_axi_awaddr,
   input  wire logic                                s_axi_awvalid,
   output logic                                     s_axi_awready,
   input  wire logic [31:0]                         s_axi_wdata,
   input  wire logic [3:0]                          s_axi_wstrb,
   input  wire logic                                s_axi_wvalid,
   output logic                                     s_axi_wready,
   output logic [1:0]                               s_axi_bresp,
   output logic                                     s_axi_bvalid,
   input  wire logic                                s_axi_bready,
   input  wire logic [7:0]                          s_axi_araddr,
   input  wire logic                                s_axi_arvalid,
   output logic                                     s_axi_arready,
   output logic [31:0]                              s_axi_rdata,
   output logic [1:0]                               s_axi_rresp,
   output logic                                     s_axi_rvalid,
   input  wire logic                                s_axi_rready,
   input  wire logic                                watchdog_pulse,
   input  wire logic                                zero_cross_signal,
   input  wire logic                                sd_voltage_stream,
   input  wire logic                                sd_current_stream,
   input  wire logic                                current_channel_flag,
   input  wire logic                                stepper_pos,
   input  wire logic                                stepper_neg,
   input  wire logic                                energy_pulse,
   input  wire logic                                energy_pulse_scaled,
   input  wire logic                                noload_flag,
   input  wire logic                                tamper_flag,
   input  wire logic                                negative_power_flag,
   output logic [otp_config_pkg::CFG_BITS-1:0]      active_config,
   output logic                                     otp_lock_bit,
   output logic                                     clock_range_select,
   output logic                                     oscillator_type_select,
   output logic [1:0]                               application_mode_select,
   output logic [1:0]                               pulse_constant_select,
   output logic                                     otp_precharge,
   output logic                                     motor_drive_positive,
   output logic                                     motor_drive_negative,
   output logic                                     led_out,
   output logic                                     clock_noload_pin,
   output logic                                     clock_noload_pin_oe,
   output logic                                     data_tamper_pin,
   output logic                                     data_tamper_pin_oe,
   output logic                                     sync_direction_pin,
   output logic                                     sync_direction_pin_oe
);
   import otp_config_pkg::*;

   // Parity nibble on top of 28 data bits
   function automatic logic [31:0] make_record(input logic [REC_DATA-1:0] d);
      logic [REC_PAR-1:0] p;
      p = '0;
      for (int i = 0; i < REC_PAR; i++) begin
         p[i] = 1'b1;
         for (int k = 0; k < 7; k++) begin
            p[i] = p[i] ^ d[4*k+i];
         end
      end
      return {p, d};
   endfunction

   logic [CFG_BITS-1:0] shadow_q;
   logic [CFG_BITS-1:0] fuse_q;
   logic [CFG_BITS-1:0] active_q;
   logic                mode_src_q;
   logic                cmd_rejected_q;
   logic                precharge_q;
   logic                lock_q;
   logic                aw_full_q;
   logic                w_full_q;
   logic [7:0]          awaddr_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                awready_q;
   logic                wready_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   logic                arready_q;
   logic                rvalid_q;
   logic [31:0]         rdata_q;
   logic [1:0]          rresp_q;
   logic                pos_q;
   logic                neg_q;
   logic                led_q;
   logic                ncl_q;
   logic                ncl_oe_q;
   logic                sdat_q;
   logic                sdat_oe_q;
   logic                sgn_q;
   logic                sgn_oe_q;

   logic       wr_exec;
   logic       cmd_wr;
   logic       mode_wr;
   logic [1:0] cmd_op;
   logic [5:0] cmd_addr;
   logic       addr_ok;
   logic       remote_rst;
   logic       cmd_accept;
   logic       src_latches;
   logic       wr_mapped;
   logic [1:0] app;

   assign wr_exec    = aw_full_q && w_full_q && !bvalid_q;
   assign cmd_wr     = wr_exec && awaddr_q == REG_CMD && wstrb_q[0];
   assign mode_wr    = wr_exec && awaddr_q == REG_MODE && wstrb_q[0];
   assign cmd_op     = wdata_q[7:6];
   assign cmd_addr   = wdata_q[5:0];
   assign addr_ok    = cmd_addr < 6'(CFG_BITS);
   // Locked part takes only the two special commands
   assign cmd_accept = cmd_wr && (cmd_op == OP_SPECIAL ? (cmd_addr == SPC_PRECHARGE ||
                       cmd_addr == SPC_REMOTE_RST) : (addr_ok && !lock_q));
   assign remote_rst = cmd_accept && cmd_op == OP_SPECIAL && cmd_addr == SPC_REMOTE_RST;
   assign src_latches = mode_src_q && !lock_q;
   assign wr_mapped  = awaddr_q <= REG_FUSE_HI && awaddr_q[1:0] == 2'h0;
   assign app        = active_q[BIT_APP +: 2];

   // AXI4-Lite write channels, address and data taken in either order
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            wready_q <= 1'b0;
         end
         if (wr_exec) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel, one cycle to the answer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= RESP_OKAY;
         unique case (s_axi_araddr)
            REG_CMD:       rdata_q <= '0;
            REG_MODE:      rdata_q <= {31'h0, mode_src_q};
            REG_STATUS:    rdata_q <= {22'h0, app, 5'h0, precharge_q, cmd_rejected_q, lock_q};
            REG_RECORD_LO: rdata_q <= make_record(active_q[REC_DATA-1:0]);
            REG_RECORD_HI: rdata_q <= make_record(active_q[CFG_BITS-1:REC_DATA]);
            REG_SHADOW_LO: rdata_q <= shadow_q[31:0];
            REG_SHADOW_HI: rdata_q <= {8'h0, shadow_q[CFG_BITS-1:32]};
            REG_FUSE_LO:   rdata_q <= fuse_q[31:0];
            REG_FUSE_HI:   rdata_q <= {8'h0, fuse_q[CFG_BITS-1:32]};
            default: begin
               rdata_q <= '0;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Shadow latches, cleared by either reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         shadow_q <= SHADOW_RESET;
      end else if (remote_rst) begin
         shadow_q <= SHADOW_RESET;
      end else if (cmd_accept && (cmd_op == OP_SHADOW_SET || cmd_op == OP_SHADOW_CLR)) begin
         shadow_q[cmd_addr] <= cmd_op == OP_SHADOW_SET;
      end
   end

   // Fuses only ever gain ones; reset_n stands for first power-up only
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fuse_q <= FUSE_BLANK;
      end else if (cmd_accept && cmd_op == OP_BURN) begin
         fuse_q[cmd_addr] <= 1'b1;
      end
   end

   // Lock comes from the fuse so that latches cannot unlock the part
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= fuse_q[BIT_LOCK];
      end
   end

   // Source selector and command status
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_src_q     <= 1'b0;
         cmd_rejected_q <= 1'b0;
         precharge_q    <= 1'b0;
      end else begin
         if (remote_rst) begin
            mode_src_q <= 1'b0;
         end else if (mode_wr && !lock_q) begin
            mode_src_q <= wdata_q[0];
         end
         if (cmd_wr) begin
            cmd_rejected_q <= !cmd_accept;
         end
         precharge_q <= cmd_accept && cmd_op == OP_SPECIAL && cmd_addr == SPC_PRECHARGE;
      end
   end

   // One registered vector so users never see a half-switched source
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         active_q <= FUSE_BLANK;
      end else begin
         active_q <= src_latches ? shadow_q : fuse_q;
      end
   end

   // Pin routing by application mode; SPI pins float in peripheral modes
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pos_q     <= 1'b0;
         neg_q     <= 1'b0;
         led_q     <= 1'b0;
         ncl_q     <= 1'b0;
         ncl_oe_q  <= 1'b0;
         sdat_q    <= 1'b0;
         sdat_oe_q <= 1'b0;
         sgn_q     <= 1'b0;
         sgn_oe_q  <= 1'b0;
      end else begin
         ncl_q     <= noload_flag;
         sdat_q    <= tamper_flag;
         sgn_q     <= negative_power_flag;
         ncl_oe_q  <= app[1];
         sdat_oe_q <= app[1];
         sgn_oe_q  <= app[1];
         unique case (app)
            APP_PERIPH_WDOG: begin
               pos_q <= zero_cross_signal;
               neg_q <= watchdog_pulse;
               led_q <= energy_pulse;
            end
            APP_PERIPH_SD: begin
               pos_q <= sd_voltage_stream;
               neg_q <= sd_current_stream;
               led_q <= current_channel_flag;
            end
            APP_STANDALONE: begin
               pos_q <= stepper_pos;
               neg_q <= stepper_neg;
               led_q <= energy_pulse;
            end
            APP_STANDALONE_K: begin
               pos_q <= stepper_pos;
               neg_q <= stepper_neg;
               led_q <= energy_pulse_scaled;
            end
         endcase
      end
   end

   assign s_axi_awready           = awready_q;
   assign s_axi_wready            = wready_q;
   assign s_axi_bvalid            = bvalid_q;
   assign s_axi_bresp             = bresp_q;
   assign s_axi_arready           = arready_q;
   assign s_axi_rvalid            = rvalid_q;
   assign s_axi_rdata             = rdata_q;
   assign s_axi_rresp             = rresp_q;
   assign active_config           = active_q;
   assign otp_lock_bit            = lock_q;
   assign clock_range_select      = active_q[BIT_CLK_RANGE];
   assign oscillator_type_select  = active_q[BIT_OSC_TYPE];
   assign application_mode_select = app;
   assign pulse_constant_select   = active_q[BIT_PULSE_K +: 2];
   assign otp_precharge           = precharge_q;
   assign motor_drive_positive    = pos_q;
   assign motor_drive_negative    = neg_q;
   assign led_out                 = led_q;
   assign clock_noload_pin        = ncl_q;
   assign clock_noload_pin_oe     = ncl_oe_q;
   assign data_tamper_pin         = sdat_q;
   assign data_tamper_pin_oe      = sdat_oe_q;
   assign sync_direction_pin      = sgn_q;
   assign sync_direction_pin_oe   = sgn_oe_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_temp_write;
      cmd_accept && cmd_op == OP_SHADOW_SET;
   endsequence

   sequence s_locked_steady;
      lock_q [*2];
   endsequence

   property p_fuse_sticky;
      (fuse_q & $past(fuse_q)) == $past(fuse_q);
   endproperty
   a_fuse_sticky: assert property (p_fuse_sticky) else $error("fuse bit cleared");

   property p_temp_write;
      s_temp_write |=> fuse_q == $past(fuse_q) && shadow_q[$past(cmd_addr)];
   endproperty
   a_temp_write: assert property (p_temp_write) else $error("temporary write wrong");

   property p_locked_reject;
      lock_q && cmd_wr && cmd_op != OP_SPECIAL |=> cmd_rejected_q && $stable(fuse_q);
   endproperty
   a_locked_reject: assert property (p_locked_reject) else $error("locked write taken");

   property p_remote_clear;
      remote_rst |=> shadow_q == SHADOW_RESET && !mode_src_q;
   endproperty
   a_remote_clear: assert property (p_remote_clear) else $error("remote reset kept latches");

   property p_source_select;
      1'b1 |=> active_q == ($past(src_latches) ? $past(shadow_q) : $past(fuse_q));
   endproperty
   a_source_select: assert property (p_source_select) else $error("active vector wrong");

   property p_locked_source;
      s_locked_steady |-> active_q == $past(fuse_q);
   endproperty
   a_locked_source: assert property (p_locked_source) else $error("latches used while locked");

   property p_lock_follows_fuse;
      fuse_q[BIT_LOCK] |=> lock_q;
   endproperty
   a_lock_follows_fuse: assert property (p_lock_follows_fuse) else $error("lock not taken");

   property p_mode0_pins;
      app == APP_PERIPH_WDOG |=> neg_q == $past(watchdog_pulse) &&
         pos_q == $past(zero_cross_signal);
   endproperty
   a_mode0_pins: assert property (p_mode0_pins) else $error("mode 0 routing wrong");

   property p_standalone_pins;
      app[1] |=> ncl_oe_q && ncl_q == $past(noload_flag) && sgn_q == $past(negative_power_flag);
   endproperty
   a_standalone_pins: assert property (p_standalone_pins) else $error("standalone pins wrong");
endmodule

/* verification/cfg_bus_host.sv */
// Register bus host model issuing configuration commands
`timescale 1ns/1ps
module cfg_bus_host (
   input  wire logic        clk_sys,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   import otp_config_pkg::*;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // One whole word per call; one command byte per configuration bit
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      // Each channel released only at its own handshake edge
      while (!(ad && dd)) begin
         @(posedge clk_sys);
         if (s_axi_awready) ad = 1'b1;
         if (s_axi_wready) dd = 1'b1;
         if (ad) s_axi_awvalid <= 1'b0;
         if (dd) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid) @(posedge clk_sys);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clk_sys);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

/* verification/otp_config_bit_store_tb.sv */
// Self-checking bench for the configuration bit store
`timescale 1ns/1ps
module otp_config_bit_store_tb;
   import otp_config_pkg::*;
   logic clk_sys, reset_n, otp_precharge, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, otp_lock_bit, clock_range_select, oscillator_type_select;
   logic motor_drive_positive, motor_drive_negative, led_out, clock_noload_pin;
   logic clock_noload_pin_oe, data_tamper_pin, data_tamper_pin_oe;
   logic sync_direction_pin, sync_direction_pin_oe;
   logic [7:0]          s_axi_awaddr, s_axi_araddr;
   logic [31:0]         s_axi_wdata, s_axi_rdata;
   logic [3:0]          s_axi_wstrb;
   logic [1:0]          s_axi_bresp, s_axi_rresp, application_mode_select, pulse_constant_select;
   logic [CFG_BITS-1:0] active_config;
   logic [11:0]         stim_q = '0;
   logic [31:0]         rv;
   logic [1:0]          rr;
   int                  miscompares = 0, comparisons = 0, cycles = 0, precharges = 0, pc0;
   cfg_bus_host cfg_bus_host_inst (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   otp_config_bit_store otp_config_bit_store_inst (.clk_sys, .reset_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .watchdog_pulse(stim_q[0]), .zero_cross_signal(stim_q[1]),
      .sd_voltage_stream(stim_q[2]), .sd_current_stream(stim_q[3]),
      .current_channel_flag(stim_q[4]), .stepper_pos(stim_q[5]), .stepper_neg(stim_q[6]),
      .energy_pulse(stim_q[7]), .energy_pulse_scaled(stim_q[8]), .noload_flag(stim_q[9]),
      .tamper_flag(stim_q[10]), .negative_power_flag(stim_q[11]), .active_config,
      .otp_lock_bit, .clock_range_select, .oscillator_type_select, .application_mode_select,
      .pulse_constant_select, .otp_precharge, .motor_drive_positive, .motor_drive_negative,
      .led_out, .clock_noload_pin, .clock_noload_pin_oe, .data_tamper_pin,
      .data_tamper_pin_oe, .sync_direction_pin, .sync_direction_pin_oe);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Pulse lasts one cycle, so it is counted rather than polled
   always @(posedge clk_sys) begin
      cycles++;
      if (otp_precharge === 1'b1) precharges++;
      if (cycles == 8000) begin
         miscompares++;
         close_out;
      end
   end
   task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic settle;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic cmd(input logic [1:0] op, input logic [5:0] a);
      cfg_bus_host_inst.wr(REG_CMD, {24'h0, op, a}, rr);
      settle;
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
      cfg_bus_host_inst.rd(a, rv, rr);
      chk(n, rv, exp);
   endtask
   // Odd parity: data bits plus parity bit hold an odd count of ones
   function automatic logic [3:0] par(input logic [27:0] d);
      logic [3:0] p;
      p = 4'hf;
      for (int j = 0; j < REC_DATA; j++) p[j % 4] = p[j % 4] ^ d[j];
      return p;
   endfunction
   function automatic logic [2:0] route(input logic [1:0] m, input logic [11:0] s);
      case (m)
         2'h0: return {s[1], s[0], s[7]};
         2'h1: return {s[2], s[3], s[4]};
         2'h2: return {s[5], s[6], s[7]};
         default: return {s[5], s[6], s[8]};
      endcase
   endfunction
   initial begin
      reset_n = 1'b0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      settle;
      chk("active", active_config, '0);
      rdc("fuse_lo", REG_FUSE_LO, 32'h0);
      $display("test reset done");
      cfg_bus_host_inst.wr(REG_MODE, 32'h1, rr);
      cmd(OP_SHADOW_SET, 6'd1);
      cmd(OP_SHADOW_SET, 6'd55);
      cmd(OP_SHADOW_SET, 6'd15);
      chk("active", active_config, 64'h0080_0000_0000_8002);
      chk("clk_range", clock_range_select, 1'b1);
      chk("pulse_k", pulse_constant_select, 2'b10);
      rdc("shadow_hi", REG_SHADOW_HI, 32'h0080_0000);
      rdc("fuse_lo", REG_FUSE_LO, 32'h0);
      cmd(OP_SHADOW_SET, 6'd56);
      rdc("status", REG_STATUS, 32'h2);
      rdc("rec_lo", REG_RECORD_LO, {par(28'h0008002), 28'h0008002});
      rdc("rec_hi", REG_RECORD_HI, {par(28'h8000000), 28'h8000000});
      $display("test shadow done");
      for (int m = 0; m < 4; m++) begin
         cmd({1'b0, m[0]}, 6'd3);
         cmd({1'b0, m[1]}, 6'd4);
         for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys);
            stim_q <= p[0] ? ~12'hb55 : 12'hb55;
            settle;
            chk("mode", application_mode_select, m[1:0]);
            chk("pins", {motor_drive_positive, motor_drive_negative, led_out},
                route(m[1:0], stim_q));
            chk("oe", {clock_noload_pin_oe, data_tamper_pin_oe, sync_direction_pin_oe},
                {3{m[1]}});
            if (m[1]) chk("spi", {clock_noload_pin, data_tamper_pin, sync_direction_pin},
                {stim_q[9], stim_q[10], stim_q[11]});
         end
      end
      $display("test routing done");
      cmd(OP_BURN, 6'd2);
      cmd(OP_SHADOW_CLR, 6'd2);
      cfg_bus_host_inst.wr(REG_MODE, 32'h0, rr);
      settle;
      chk("osc", {oscillator_type_select, clock_range_select}, 2'b10);
      rdc("fuse_lo", REG_FUSE_LO, 32'h4);
      pc0 = precharges;
      cmd(OP_SPECIAL, SPC_PRECHARGE);
      chk("precharge", precharges - pc0, 1);
      cmd(OP_SPECIAL, SPC_REMOTE_RST);
      rdc("shadow_lo", REG_SHADOW_LO, 32'h0);
      rdc("shadow_hi", REG_SHADOW_HI, 32'h0);
      rdc("fuse_lo", REG_FUSE_LO, 32'h4);
      cfg_bus_host_inst.wr(8'h40, 32'h1, rr);
      chk("bresp", rr, RESP_SLVERR);
      cfg_bus_host_inst.rd(8'h40, rv, rr);
      chk("rresp", rr, RESP_SLVERR);
      $display("test fuse done");
      cmd(OP_SHADOW_SET, 6'd1);
      cfg_bus_host_inst.wr(REG_MODE, 32'h1, rr);
      cmd(OP_BURN, 6'd0);
      settle;
      chk("lock", otp_lock_bit, 1'b1);
      chk("active", active_config, 64'h5);
      cmd(OP_SHADOW_SET, 6'd3);
      rdc("status", REG_STATUS, 32'h3);
      cmd(OP_BURN, 6'd5);
      rdc("fuse_lo", REG_FUSE_LO, 32'h5);
      pc0 = precharges;
      cmd(OP_SPECIAL, SPC_PRECHARGE);
      chk("precharge", precharges - pc0, 1);
      rdc("status", REG_STATUS, 32'h1);
      $display("test lock done");
      close_out;
   end
endmodule
